//--- design/sac_clkdiv.sv
`timescale 1ns/100ps
module sac_clkdiv
#(
   parameter int RATIO = 12
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic restart,
   output logic tick
);
   localparam int CW = $clog2(RATIO);
   localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;
   logic wrap;

   // refuse ratios that give no slower rate
   if (RATIO < 2)
   begin : g_bad_ratio
      $error("sac_clkdiv: RATIO must be at least 2");
   end

   // wrap detection and next count
   assign wrap = (cnt_ff == LAST);
   assign nxt_cnt = (restart || wrap) ? '0 : cnt_ff + 1'b1;
   assign tick = wrap && !restart;

   // divider counter, realigned by restart
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end
endmodule : sac_clkdiv

//--- design/sac_sar.sv
`timescale 1ns/100ps
module sac_sar
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic step,
   input wire logic keep_bit,
   output logic [WIDTH-1:0] trial,
   output logic [WIDTH-1:0] resolved,
   output logic last
);
   logic [WIDTH-1:0] trial_ff;
   logic [WIDTH-1:0] mask_ff;
   logic [WIDTH-1:0] nxt_trial;
   logic [WIDTH-1:0] nxt_mask;

   // refuse widths the sequencer cannot walk
   if (WIDTH < 2)
   begin : g_bad_width
      $error("sac_sar: WIDTH must be at least 2");
   end

   // per bit: keep or drop the bit under test, arm the next one
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      assign resolved[i] = mask_ff[i] ? keep_bit : trial_ff[i];
      if (i == WIDTH - 1)
      begin : g_top
         assign nxt_trial[i] = load ? 1'b1 : (step ? resolved[i] : trial_ff[i]);
         assign nxt_mask[i] = load ? 1'b1 : (step ? 1'b0 : mask_ff[i]);
      end
      else
      begin : g_low
         assign nxt_trial[i] = load ? 1'b0 :
                               (step ? (resolved[i] | mask_ff[i+1]) : trial_ff[i]);
         assign nxt_mask[i] = load ? 1'b0 : (step ? mask_ff[i+1] : mask_ff[i]);
      end
   end

   assign trial = trial_ff;
   assign last = mask_ff[0];

   // trial code and bit under test
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         trial_ff <= '0;
         mask_ff <= '0;
      end
      else
      begin
         trial_ff <= nxt_trial;
         mask_ff <= nxt_mask;
      end
   end
endmodule : sac_sar

//--- design/sac_top.sv
`timescale 1ns/100ps
// Behaviour
// - conversion clock is oscillator divided by twelve
// - conversion length follows divided clock, about 70us
// - 8-bit result register, read only
// - start write with power bit set begins conversion; any start write clears done
// - done set at end; result valid then
// - one conversion per start write
// - start during conversion abandons and restarts
// - start bit is write-only, reads zero
// - done with enable requests vector 4 interrupt
// - enable at bit 7, done at 6
// - start bit 5, power bit 4, rest unused
// - power bit off puts converter idle
// - comparator stays on in wait unless off
// - reset stops conversion, control becomes 40h
// - converts and interrupts during core wait
module sac_top
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [sac_pkg::ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [sac_pkg::DATA_W-1:0] bus_wdata,
   output logic [sac_pkg::DATA_W-1:0] bus_rdata,
   input wire logic cmp_pin,
   output logic [sac_pkg::DATA_W-1:0] dac_code,
   output logic converter_power_on,
   output logic comparator_en,
   output logic conv_busy,
   output logic done_irq
);
   import sac_pkg::*;

   localparam int TCW = $clog2(STEP_TICKS > SAMPLE_TICKS ? STEP_TICKS : SAMPLE_TICKS) + 1;
   localparam logic [TCW-1:0] STEP_LAST = TCW'(STEP_TICKS - 1);
   localparam logic [TCW-1:0] SAMPLE_LAST = TCW'(SAMPLE_TICKS - 1);
   // msb-only trial code presented right at a start
   localparam logic [DATA_W-1:0] FIRST_TRIAL = {1'b1, {(DATA_W-1){1'b0}}};

   // refuse a timing split the sequencer cannot serve
   if (STEP_TICKS < 1 || SAMPLE_TICKS < 1)
   begin : g_bad_timing
      $error("sac_top: conversion ticks too few for the step split");
   end

   // refuse a step count that does not walk every result bit
   if (SAR_STEPS != DATA_W)
   begin : g_bad_steps
      $error("sac_top: step count must equal the result width");
   end

   // refuse control fields that fall outside the register byte
   if (IRQ_EN_BIT >= DATA_W || DONE_BIT >= DATA_W ||
       START_BIT >= DATA_W || POWER_BIT >= DATA_W)
   begin : g_bad_fields
      $error("sac_top: control field position outside the register");
   end

   // control register fields
   logic irq_en_ff;
   logic done_ff;
   logic power_ff;
   logic nxt_irq_en;
   logic nxt_done;
   logic nxt_power;

   // result register and bus read data
   logic [DATA_W-1:0] result_ff;
   logic [DATA_W-1:0] nxt_result;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;

   // comparator synchroniser
   logic cmp_meta_ff;
   logic cmp_sync_ff;

   // sequencer
   sac_state_e state_ff;
   sac_state_e nxt_state;
   logic [TCW-1:0] tick_cnt_ff;
   logic [TCW-1:0] nxt_tick_cnt;

   // registered outputs
   logic irq_ff;
   logic busy_ff;
   logic [DATA_W-1:0] dac_ff;
   logic nxt_busy;
   logic [DATA_W-1:0] nxt_dac;

   // decode and control wires
   logic sel_control;
   logic sel_result;
   logic ctrl_wr;
   logic start_req;
   logic start_go;
   logic power_off_req;
   logic conv_tick;
   logic phase_end;
   logic sample_end;
   logic step_go;
   logic conv_end;
   logic sar_last;
   logic [DATA_W-1:0] sar_trial;
   logic [DATA_W-1:0] sar_resolved;
   logic [DATA_W-1:0] control_view;

   // address decode
   assign sel_control = (bus_addr == CONTROL_ADDR);
   assign sel_result = (bus_addr == RESULT_ADDR);
   assign ctrl_wr = bus_wr && sel_control;

   assign start_req = ctrl_wr && bus_wdata[START_BIT];

   assign power_off_req = ctrl_wr && !bus_wdata[POWER_BIT];

   // start honoured only with power kept on
   assign start_go = start_req && bus_wdata[POWER_BIT];

   // conversion clock enable, realigned at each start
   sac_clkdiv
   #(
      .RATIO(DIV_RATIO)
   )
   u_div
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .restart(start_go),
      .tick(conv_tick)
   );

   sac_sar
   #(
      .WIDTH(DATA_W)
   )
   u_sar
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(start_go),
      .step(step_go),
      .keep_bit(cmp_sync_ff),
      .trial(sar_trial),
      .resolved(sar_resolved),
      .last(sar_last)
   );

   // phase boundaries counted in conversion ticks
   assign sample_end = conv_tick && (tick_cnt_ff == SAMPLE_LAST);
   assign phase_end = conv_tick && (tick_cnt_ff == STEP_LAST);
   assign step_go = (state_ff == SAC_STEP) && phase_end && !start_go && !power_off_req;
   assign conv_end = step_go && sar_last;

   // sequencer next state
   always_comb
   begin
      nxt_state = state_ff;
      nxt_tick_cnt = tick_cnt_ff;
      if (start_go)
      begin
         nxt_state = SAC_SAMPLE;
         nxt_tick_cnt = '0;
      end
      else if (power_off_req)
      begin
         nxt_state = SAC_IDLE;
         nxt_tick_cnt = '0;
      end
      else
      begin
         case (state_ff)
            SAC_IDLE:
            begin
               nxt_tick_cnt = '0;
            end
            SAC_SAMPLE:
            begin
               if (sample_end)
               begin
                  nxt_state = SAC_STEP;
                  nxt_tick_cnt = '0;
               end
               else if (conv_tick)
               begin
                  nxt_tick_cnt = tick_cnt_ff + 1'b1;
               end
            end
            SAC_STEP:
            begin
               if (phase_end)
               begin
                  nxt_state = sar_last ? SAC_IDLE : SAC_STEP;
                  nxt_tick_cnt = '0;
               end
               else if (conv_tick)
               begin
                  nxt_tick_cnt = tick_cnt_ff + 1'b1;
               end
            end
            default:
            begin
               nxt_state = SAC_IDLE;
               nxt_tick_cnt = '0;
            end
         endcase
      end
   end

   assign nxt_irq_en = ctrl_wr ? bus_wdata[IRQ_EN_BIT] : irq_en_ff;

   assign nxt_power = ctrl_wr ? bus_wdata[POWER_BIT] : power_ff;

   // start clears done; end sets it
   assign nxt_done = start_req ? 1'b0 : (conv_end ? 1'b1 : done_ff);

   // result only from the converter, never from the bus
   assign nxt_result = conv_end ? sar_resolved : result_ff;

   // start bit reads zero; low bits read zero
   always_comb
   begin
      control_view = '0;
      control_view[IRQ_EN_BIT] = irq_en_ff;
      control_view[DONE_BIT] = done_ff;
      control_view[POWER_BIT] = power_ff;
   end

   // read mux, unmapped addresses read zero
   assign nxt_rdata = !bus_rd ? rdata_ff :
                      sel_control ? control_view :
                      sel_result ? result_ff : '0;

   // comparator pin synchroniser
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cmp_meta_ff <= 1'b0;
         cmp_sync_ff <= 1'b0;
      end
      else
      begin
         cmp_meta_ff <= cmp_pin;
         cmp_sync_ff <= cmp_meta_ff;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= SAC_IDLE;
         tick_cnt_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   // control register loads 40h at reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irq_en_ff <= CONTROL_RESET[IRQ_EN_BIT];
         done_ff <= CONTROL_RESET[DONE_BIT];
         power_ff <= CONTROL_RESET[POWER_BIT];
      end
      else
      begin
         irq_en_ff <= nxt_irq_en;
         done_ff <= nxt_done;
         power_ff <= nxt_power;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         result_ff <= RESULT_RESET;
      else
         result_ff <= nxt_result;
   end

   // bus read data, held between reads
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata_ff <= '0;
      else
         rdata_ff <= nxt_rdata;
   end

   // masked done request; independent of core wait
   // no wait input reaches this flop, so the request can wake a sleeping core
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq_ff <= 1'b0;
      else
         irq_ff <= nxt_done && nxt_irq_en;
   end

   // busy follows the state about to be entered, so it drops with done
   assign nxt_busy = (nxt_state != SAC_IDLE);

   // msb trial at a start, so the analog side need not wait a cycle
   assign nxt_dac = start_go ? FIRST_TRIAL : sar_trial;

   // busy flag towards the core
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         busy_ff <= 1'b0;
      else
         busy_ff <= nxt_busy;
   end

   // trial code towards the analog side
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         dac_ff <= '0;
      else
         dac_ff <= nxt_dac;
   end

   // output drive
   assign bus_rdata = rdata_ff;
   assign dac_code = dac_ff;
   // comparator follows power only, wait has no say
   assign comparator_en = power_ff;
   assign converter_power_on = power_ff;
   assign conv_busy = busy_ff;
   assign done_irq = irq_ff;
endmodule : sac_top

//--- pkg/sac_pkg.sv
package sac_pkg;
   // data-space bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register addresses
   localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'hd0;
   localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'hd1;

   // control register field positions
   localparam int IRQ_EN_BIT = 7;
   localparam int DONE_BIT = 6;
   localparam int START_BIT = 5;
   localparam int POWER_BIT = 4;

   // reset values
   localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h40;
   localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;

   // interrupt vector served by the done request
   localparam int IRQ_VECTOR = 4;

   // conversion clock is the oscillator divided by this
   localparam int DIV_RATIO = 12;

   // typical conversion time at the reference oscillator rate
   localparam int CONV_TIME_NS = 70000;
   localparam int OSC_REF_KHZ = 8000;

   // conversion clock ticks in one conversion, rounded down
   localparam int CONV_TICKS = (CONV_TIME_NS * OSC_REF_KHZ) / (1000000 * DIV_RATIO);

   // successive-approximation steps and their share of the ticks
   localparam int SAR_STEPS = 8;
   localparam int STEP_TICKS = CONV_TICKS / SAR_STEPS;
   localparam int SAMPLE_TICKS = CONV_TICKS - (SAR_STEPS * STEP_TICKS);

   // conversion sequencer states
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_SAMPLE,
      SAC_STEP
   } sac_state_e;
endpackage : sac_pkg

//--- testbench/sac_analog_src.sv
`timescale 1ns/100ps
module sac_analog_src
(
   input logic clk_sys,
   input logic [sac_pkg::DATA_W-1:0] level,
   input logic [sac_pkg::DATA_W-1:0] dac_code,
   input logic comparator_en,
   output logic cmp_pin
);
   import sac_pkg::*;
   logic junk_ff = 1'b0;
   // scrambled output while the comparator is off
   always @(posedge clk_sys)
      junk_ff <= ~junk_ff;
   assign cmp_pin = comparator_en ? (level >= dac_code) : junk_ff;
endmodule : sac_analog_src

//--- testbench/sac_top_props.sv
`timescale 1ns/100ps
module sac_top_props
(
   input logic clk_sys,
   input logic rst,
   input logic [sac_pkg::ADDR_W-1:0] bus_addr,
   input logic bus_wr,
   input logic bus_rd,
   input logic [sac_pkg::DATA_W-1:0] bus_wdata,
   input logic [sac_pkg::DATA_W-1:0] bus_rdata,
   input logic cmp_pin,
   input logic [sac_pkg::DATA_W-1:0] dac_code,
   input logic converter_power_on,
   input logic comparator_en,
   input logic conv_busy,
   input logic done_irq
);
   import sac_pkg::*;
   logic [9:0] run_cnt_ff;
   logic [9:0] nxt_run_cnt;
   logic go;
   logic ctl_wr;
   logic ctl_rd;
   // control accesses and accepted start
   assign ctl_wr = bus_wr && (bus_addr == CONTROL_ADDR);
   assign ctl_rd = bus_rd && (bus_addr == CONTROL_ADDR) && !bus_wr;
   assign go = ctl_wr && bus_wdata[START_BIT] && bus_wdata[POWER_BIT];
   assign nxt_run_cnt = go ? 10'h001 : run_cnt_ff + {9'h000, conv_busy};
   // busy cycles since the last start
   always_ff @(posedge clk_sys or posedge rst)
      if (rst)
         run_cnt_ff <= 10'h000;
      else
         run_cnt_ff <= nxt_run_cnt;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_start_begins: assert property (go |=> conv_busy && dac_code == 8'h80)
      else $error("start did not begin at msb trial");
   a_conv_length: assert property ($fell(conv_busy) && converter_power_on |->
      run_cnt_ff >= 10'd548 && run_cnt_ff <= 10'd556)
      else $error("conversion length off");
   a_busy_bounded: assert property (conv_busy |-> run_cnt_ff <= 10'd556)
      else $error("conversion overran");
   a_no_self_start: assert property ($rose(conv_busy) |-> $past(go))
      else $error("conversion began unasked");
   a_irq_cleared: assert property (conv_busy && $past(conv_busy) |-> !done_irq)
      else $error("request during conversion");
   a_ctrl_view: assert property (ctl_rd |=> !bus_rdata[START_BIT] && bus_rdata[3:0] == 4'h0)
      else $error("start or unused bits read nonzero");
   a_power_follow: assert property (ctl_wr |=>
      converter_power_on == $past(bus_wdata[POWER_BIT]) && comparator_en == converter_power_on)
      else $error("power bit not taken");
   a_off_idle: assert property (!converter_power_on |-> !conv_busy)
      else $error("busy while powered off");
   a_unmapped_zero: assert property (bus_rd && bus_addr != RESULT_ADDR &&
      bus_addr != CONTROL_ADDR |=> bus_rdata == 8'h00)
      else $error("unmapped read nonzero");
   a_irq_masked: assert property (ctl_rd && !conv_busy |=>
      done_irq == (bus_rdata[IRQ_EN_BIT] && bus_rdata[DONE_BIT]))
      else $error("request not equal to done and enable");
endmodule : sac_top_props

bind sac_top sac_top_props i_props (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .cmp_pin(cmp_pin), .dac_code(dac_code), .converter_power_on(converter_power_on),
   .comparator_en(comparator_en), .conv_busy(conv_busy), .done_irq(done_irq));

//--- testbench/sar_adc_control_test.sv
`timescale 1ns/100ps
`define CHK(g, e) chk(g, e)
module sar_adc_control_test;
   import sac_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] bus_addr = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [DATA_W-1:0] bus_wdata = 8'h00;
   logic [DATA_W-1:0] level = 8'h00;
   logic [DATA_W-1:0] bus_rdata, dac_code, v;
   logic cmp_pin, converter_power_on, comparator_en, conv_busy, done_irq;
   logic [7:0] codes [3] = '{8'h00, 8'hff, 8'h5a};
   int error_cnt = 0;
   int comparisons = 0;
   int n;

   always #5 clk_sys = ~clk_sys;

   sac_top i_dut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cmp_pin(cmp_pin),
      .dac_code(dac_code), .converter_power_on(converter_power_on),
      .comparator_en(comparator_en), .conv_busy(conv_busy), .done_irq(done_irq));
   sac_analog_src i_src (.clk_sys(clk_sys), .level(level), .dac_code(dac_code),
      .comparator_en(comparator_en), .cmp_pin(cmp_pin));

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd

   // count edges until the conversion ends
   task automatic wait_idle(output int cnt);
      cnt = 0;
      do
      begin
         @(posedge clk_sys);
         #1 cnt++;
      end
      while (conv_busy !== 1'b0 && cnt < 1000);
      if (cnt >= 1000)
      begin
         error_cnt++;
         $display("BAD %0t conversion hung", $time);
         tally_and_finish();
      end
   endtask : wait_idle

   task automatic convert(input logic [7:0] c);
      level = c;
      wr(CONTROL_ADDR, 8'h90);
      wr(CONTROL_ADDR, 8'hb0);
      rd(CONTROL_ADDR, v);
      `CHK(v, 8'h90);
      `CHK(dac_code, 8'h80);
      `CHK(8'(converter_power_on), 8'h01);
      wait_idle(n);
      `CHK(8'(n >= 545 && n <= 554), 8'h01);
      @(posedge clk_sys);
      #1 `CHK(8'(done_irq), 8'h01);
      rd(RESULT_ADDR, v);
      `CHK(v, c);
      rd(CONTROL_ADDR, v);
      `CHK(v, 8'hd0);
   endtask : convert

   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(CONTROL_ADDR, v);
      `CHK(v, CONTROL_RESET);
      rd(RESULT_ADDR, v);
      `CHK(v, 8'h00);
      rd(8'hd2, v);
      `CHK(v, 8'h00);
      foreach (codes[i])
         convert(codes[i]);
      wr(RESULT_ADDR, 8'h33);
      rd(RESULT_ADDR, v);
      `CHK(v, 8'h5a);
      wr(CONTROL_ADDR, 8'h10);
      rd(CONTROL_ADDR, v);
      `CHK(v, 8'h50);
      `CHK(8'(done_irq), 8'h00);
      repeat (600) @(posedge clk_sys);
      #1 `CHK(8'(conv_busy), 8'h00);
      level = 8'hc3;
      wr(CONTROL_ADDR, 8'h30);
      repeat (200) @(posedge clk_sys);
      wr(CONTROL_ADDR, 8'h30);
      wait_idle(n);
      `CHK(8'(n >= 548 && n <= 556), 8'h01);
      rd(RESULT_ADDR, v);
      `CHK(v, 8'hc3);
      wr(CONTROL_ADDR, 8'h20);
      rd(CONTROL_ADDR, v);
      `CHK(v, 8'h00);
      `CHK(8'(conv_busy), 8'h00);
      wr(CONTROL_ADDR, 8'h30);
      repeat (100) @(posedge clk_sys);
      wr(CONTROL_ADDR, 8'h00);
      #1 `CHK(8'({conv_busy, comparator_en, converter_power_on}), 8'h00);
      wr(CONTROL_ADDR, 8'h30);
      repeat (50) @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      #1 `CHK(8'(conv_busy), 8'h00);
      `CHK(dac_code, 8'h00);
      rd(CONTROL_ADDR, v);
      `CHK(v, CONTROL_RESET);
      rd(RESULT_ADDR, v);
      `CHK(v, 8'h00);
      `CHK(8'(done_irq), 8'h00);
      tally_and_finish();
   end
endmodule : sar_adc_control_test
